/* File: shared/hdr_rom_defs.svh */
`ifndef HDR_ROM_DEFS_SVH
`define HDR_ROM_DEFS_SVH
// Functional notes
// - device descriptor 18 bytes, 12 01 10 01
// - hub class 09, subclass/protocol 0, ep0 64
// - vendor/product ids from id programming command
// - release bytes 00 then silicon release setting
// - string indexes 01/02 only when strings enabled
// - serial index 00, one configuration
// - configuration 9 bytes, total length 19 00
// - one interface, value one, attributes A0
// - max power 32, 2 mA units
// - interface 9 bytes, type 04, class 09
// - endpoint 7 bytes, 81, interrupt 03
// - endpoint packet 01 00, interval FF
// - hub descriptor 9 bytes, 29, ports 03
// - characteristics 0D or 15 by overcurrent option
// - power good 32, controller current 64
// - removable 38, power mask FF
// - strings refused until mode command enables them

// descriptor lengths
`define HDR_DEV_LEN 8'h12
`define HDR_CFG_TOTAL 8'h19
`define HDR_HUB_LEN 8'h09
`define HDR_LANG_LEN 8'h04
// descriptor type codes as seen in the request
`define HDR_TYPE_DEV 8'h01
`define HDR_TYPE_CFG 8'h02
`define HDR_TYPE_STR 8'h03
`define HDR_TYPE_HUB 8'h29
`define HDR_TYPE_HUB_OLD 8'h00
// fixed images, byte 0 in the low bits
`define HDR_DEV_HEAD 64'h4000000901100112
`define HDR_CFG_IMAGE 200'hFF00010381050700000009010000040932A000010100190209
`define HDR_HUB_LOW 24'h032909
`define HDR_HUB_HIGH 40'hFF38643200
`define HDR_LANG_IMAGE 32'h04090304
// device and hub descriptor field offsets
`define HDR_OFS_VID_LO 8'h08
`define HDR_OFS_VID_HI 8'h09
`define HDR_OFS_PID_LO 8'h0A
`define HDR_OFS_PID_HI 8'h0B
`define HDR_OFS_REL_LO 8'h0C
`define HDR_OFS_REL_HI 8'h0D
`define HDR_OFS_MFR 8'h0E
`define HDR_OFS_PROD 8'h0F
`define HDR_OFS_SER 8'h10
`define HDR_OFS_NCFG 8'h11
`define HDR_OFS_HUB_CHAR 8'h03
`define HDR_OFS_HUB_CHAR_HI 8'h04
// variable field values
`define HDR_REL_LO 8'h00
`define HDR_MFR_IDX 8'h01
`define HDR_PROD_IDX 8'h02
`define HDR_NO_STR 8'h00
`define HDR_NUM_CFG 8'h01
`define HDR_HUB_CHAR_OC 8'h0D
`define HDR_HUB_CHAR_NOC 8'h15
`define HDR_LANG_INDEX 8'h00
// default control endpoint packet size
`define HDR_EP0_MAX 7'h40
`endif

/* File: shared/hdr_pkg.sv */
package hdr_pkg;
   // which descriptor image is being streamed
   typedef enum logic [1:0] {SEL_DEV, SEL_CFG, SEL_HUB, SEL_LANG} hdr_sel_type;
   // sequencer states
   typedef enum logic {ST_IDLE, ST_SEND} hdr_state_type;
   // descriptor request from the request decoder
   typedef struct packed {
      logic hubClass;
      logic [7:0] descType;
      logic [7:0] descIndex;
      logic [15:0] length;
   } hdr_req_type;
   // byte stream toward the packet engine
   typedef struct packed {
      logic valid;
      logic [7:0] data;
      logic pktEnd;
      logic last;
   } hdr_tx_type;
endpackage

/* File: hw/hdr_rom.sv */
`include "hdr_rom_defs.svh"

module hdr_rom #(
   parameter logic [6:0] PKT_MAX = `HDR_EP0_MAX
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic idLoad,
   input wire logic [15:0] vidIn,
   input wire logic [15:0] pidIn,
   input wire logic modeLoad,
   input wire logic modeStringEnable,
   input wire logic [7:0] siliconRelease,
   input wire logic overcurrentUsed,
   input wire logic reqValid,
   input wire hdr_pkg::hdr_req_type req,
   input wire logic txReady,
   output hdr_pkg::hdr_tx_type txOut,
   output logic reqStall,
   output logic busy,
   output logic stringEnabled
);

   ////////////////////////////////////////////////////////////////////
   // descriptor byte lookup

   // one byte of the selected image; variable fields patched in
   function automatic logic [7:0] romByte(
      input hdr_pkg::hdr_sel_type sel,
      input logic [7:0] ofs,
      input logic [15:0] vid,
      input logic [15:0] pid,
      input logic strEn,
      input logic ocUsed
   );
      logic [7:0] b;
      logic [63:0] dev;
      logic [199:0] cfg;
      logic [39:0] hubHi;
      logic [23:0] hubLo;
      logic [31:0] lang;
      b = 8'h00;
      dev = `HDR_DEV_HEAD;
      cfg = `HDR_CFG_IMAGE;
      hubHi = `HDR_HUB_HIGH;
      hubLo = `HDR_HUB_LOW;
      lang = `HDR_LANG_IMAGE;
      case (sel)
         hdr_pkg::SEL_DEV:
         begin
            case (ofs)
               `HDR_OFS_VID_LO: b = vid[7:0];
               `HDR_OFS_VID_HI: b = vid[15:8];
               `HDR_OFS_PID_LO: b = pid[7:0];
               `HDR_OFS_PID_HI: b = pid[15:8];
               `HDR_OFS_REL_LO: b = `HDR_REL_LO;
               `HDR_OFS_REL_HI: b = siliconRelease;
               `HDR_OFS_MFR: b = strEn ? `HDR_MFR_IDX : `HDR_NO_STR;
               `HDR_OFS_PROD: b = strEn ? `HDR_PROD_IDX : `HDR_NO_STR;
               `HDR_OFS_SER: b = `HDR_NO_STR;
               `HDR_OFS_NCFG: b = `HDR_NUM_CFG;
               // head bytes: length, type, bcd usb, class, ep0 size
               default: b = dev[ofs[2:0]*8 +: 8];
            endcase
         end
         // configuration, interface and endpoint back to back
         hdr_pkg::SEL_CFG: b = cfg[ofs[4:0]*8 +: 8];
         hdr_pkg::SEL_HUB:
         begin
            if (ofs == `HDR_OFS_HUB_CHAR)
               b = ocUsed ? `HDR_HUB_CHAR_OC : `HDR_HUB_CHAR_NOC;
            else if (ofs < `HDR_OFS_HUB_CHAR)
               b = hubLo[ofs[1:0]*8 +: 8];
            else
               b = hubHi[3'(ofs - `HDR_OFS_HUB_CHAR_HI)*8 +: 8];
         end
         hdr_pkg::SEL_LANG: b = lang[ofs[1:0]*8 +: 8];
         default: b = 8'h00;
      endcase
      return b;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // settings loaded by commands

   logic [15:0] vid_ff;  // vendor id
   logic [15:0] pid_ff;  // product id
   logic strEn_ff;  // string table enable
   logic [15:0] nxt_vid;
   logic [15:0] nxt_pid;
   logic nxt_strEn;

   // next values of the id and mode settings
   always_comb
   begin
      nxt_vid = vid_ff;
      nxt_pid = pid_ff;
      nxt_strEn = strEn_ff;
      if (idLoad)
      begin
         nxt_vid = vidIn;
         nxt_pid = pidIn;
      end
      if (modeLoad)
         nxt_strEn = modeStringEnable;
   end

   // strings start disabled, so a fresh hub shows no string indexes
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         vid_ff <= 16'h0000;
         pid_ff <= 16'h0000;
         strEn_ff <= 1'b0;
      end
      else if (ce)
      begin
         vid_ff <= nxt_vid;
         pid_ff <= nxt_pid;
         strEn_ff <= nxt_strEn;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // request decode

   hdr_pkg::hdr_state_type state_ff;
   logic startOk;  // request names a servable descriptor
   hdr_pkg::hdr_sel_type reqSel;
   logic [7:0] reqLen;  // full length of the chosen image
   logic isHub;

   // map the request onto an image; anything else is stalled
   always_comb
   begin
      startOk = 1'b1;
      reqSel = hdr_pkg::SEL_DEV;
      reqLen = `HDR_DEV_LEN;
      isHub = req.descType == `HDR_TYPE_HUB
         || req.descType == `HDR_TYPE_HUB_OLD;
      if (req.hubClass)
      begin
         reqSel = hdr_pkg::SEL_HUB;
         reqLen = `HDR_HUB_LEN;
         startOk = isHub;
      end
      else
      begin
         case (req.descType)
            `HDR_TYPE_DEV: reqSel = hdr_pkg::SEL_DEV;
            `HDR_TYPE_CFG:
            begin
               reqSel = hdr_pkg::SEL_CFG;
               reqLen = `HDR_CFG_TOTAL;
            end
            `HDR_TYPE_STR:
            begin
               // only the language table lives here
               reqSel = hdr_pkg::SEL_LANG;
               reqLen = `HDR_LANG_LEN;
               startOk = strEn_ff
                  && req.descIndex == `HDR_LANG_INDEX;
            end
            default: startOk = 1'b0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // byte sequencer

   hdr_pkg::hdr_sel_type sel_ff;
   logic [7:0] ofs_ff;  // next offset to fetch
   logic [15:0] remain_ff;  // bytes still to hand out
   logic [6:0] pktCnt_ff;  // bytes already in this packet
   hdr_pkg::hdr_tx_type tx_ff;
   logic stall_ff;
   logic busy_ff;
   hdr_pkg::hdr_state_type nxt_state;
   hdr_pkg::hdr_sel_type nxt_sel;
   logic [7:0] nxt_ofs;
   logic [15:0] nxt_remain;
   logic [6:0] nxt_pktCnt;
   hdr_pkg::hdr_tx_type nxt_tx;
   logic nxt_stall;
   logic nxt_busy;
   logic slotFree;  // output register may take a new byte

   // a held byte is never replaced before the consumer takes it
   always_comb
   begin
      nxt_state = state_ff;
      nxt_sel = sel_ff;
      nxt_ofs = ofs_ff;
      nxt_remain = remain_ff;
      nxt_pktCnt = pktCnt_ff;
      nxt_tx = tx_ff;
      nxt_stall = 1'b0;
      slotFree = !tx_ff.valid || txReady;
      if (slotFree)
         nxt_tx.valid = 1'b0;
      case (state_ff)
         hdr_pkg::ST_IDLE:
         begin
            // requests while a transfer runs are ignored
            if (reqValid && !tx_ff.valid)
            begin
               if (startOk)
               begin
                  nxt_state = hdr_pkg::ST_SEND;
                  nxt_sel = reqSel;
                  nxt_ofs = 8'h00;
                  nxt_pktCnt = 7'h00;
                  // stop at the shorter of both lengths
                  if (req.length < {8'h00, reqLen})
                     nxt_remain = req.length;
                  else
                     nxt_remain = {8'h00, reqLen};
               end
               else
                  nxt_stall = 1'b1;
            end
         end
         hdr_pkg::ST_SEND:
         begin
            if (slotFree)
            begin
               if (remain_ff == 16'h0000)
                  nxt_state = hdr_pkg::ST_IDLE;
               else
               begin
                  nxt_tx.valid = 1'b1;
                  nxt_tx.data = romByte(sel_ff, ofs_ff, vid_ff, pid_ff,
                     strEn_ff, overcurrentUsed);
                  nxt_tx.last = remain_ff == 16'h0001;
                  nxt_tx.pktEnd = nxt_tx.last
                     || pktCnt_ff == PKT_MAX - 7'h01;
                  nxt_ofs = ofs_ff + 8'h01;
                  nxt_remain = remain_ff - 16'h0001;
                  nxt_pktCnt = nxt_tx.pktEnd ? 7'h00
                     : pktCnt_ff + 7'h01;
               end
            end
         end
         default: nxt_state = hdr_pkg::ST_IDLE;
      endcase
      nxt_busy = nxt_state != hdr_pkg::ST_IDLE || nxt_tx.valid;
   end

   // sequencer registers; txOut, reqStall and busy come straight from here
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_ff <= hdr_pkg::ST_IDLE;
         sel_ff <= hdr_pkg::SEL_DEV;
         ofs_ff <= 8'h00;
         remain_ff <= 16'h0000;
         pktCnt_ff <= 7'h00;
         tx_ff <= '0;
         stall_ff <= 1'b0;
         busy_ff <= 1'b0;
      end
      else if (ce)
      begin
         state_ff <= nxt_state;
         sel_ff <= nxt_sel;
         ofs_ff <= nxt_ofs;
         remain_ff <= nxt_remain;
         pktCnt_ff <= nxt_pktCnt;
         tx_ff <= nxt_tx;
         stall_ff <= nxt_stall;
         busy_ff <= nxt_busy;
      end
   end

   assign txOut = tx_ff;
   assign reqStall = stall_ff;
   assign busy = busy_ff;
   assign stringEnabled = strEn_ff;

   ////////////////////////////////////////////////////////////////////
   // checks

   logic startDev;  // device descriptor transfer begins
   assign startDev = ce && reqValid && state_ff == hdr_pkg::ST_IDLE
      && !tx_ff.valid && !req.hubClass && req.descType == `HDR_TYPE_DEV
      && req.length != 16'h0000;

   a_dev_first_byte: assert property (
      @(posedge clk) disable iff (!rst_b)
      startDev ##1 ce |=> tx_ff.valid && tx_ff.data == `HDR_DEV_LEN)
      else $error("device transfer did not open with its length");

   a_str_refused: assert property (
      @(posedge clk) disable iff (!rst_b)
      ce && reqValid && state_ff == hdr_pkg::ST_IDLE && !tx_ff.valid
      && !req.hubClass && req.descType == `HDR_TYPE_STR && !strEn_ff
      |=> stall_ff && state_ff == hdr_pkg::ST_IDLE)
      else $error("string served while disabled");

   a_hub_old_type: assert property (
      @(posedge clk) disable iff (!rst_b)
      ce && reqValid && state_ff == hdr_pkg::ST_IDLE && !tx_ff.valid
      && req.hubClass && req.descType == `HDR_TYPE_HUB_OLD
      |=> !stall_ff && state_ff == hdr_pkg::ST_SEND)
      else $error("hub request with old type refused");

   a_last_bound: assert property (
      @(posedge clk) disable iff (!rst_b)
      tx_ff.valid && tx_ff.last |-> remain_ff == 16'h0000)
      else $error("last byte flagged with bytes left");

   a_tx_hold: assert property (
      @(posedge clk) disable iff (!rst_b)
      tx_ff.valid && !txReady |=> tx_ff.valid && $stable(tx_ff.data))
      else $error("byte dropped before acceptance");

   a_pkt_split: assert property (
      @(posedge clk) disable iff (!rst_b)
      tx_ff.valid && !tx_ff.pktEnd |-> pktCnt_ff != 7'h00)
      else $error("packet longer than control endpoint size");

   a_id_load: assert property (
      @(posedge clk) disable iff (!rst_b)
      ce && idLoad |=> vid_ff == $past(vidIn) && pid_ff == $past(pidIn))
      else $error("id programming not taken");

   a_mode_load: assert property (
      @(posedge clk) disable iff (!rst_b)
      ce && modeLoad |=> stringEnabled == $past(modeStringEnable))
      else $error("string enable not taken");

   a_busy_idle: assert property (
      @(posedge clk) disable iff (!rst_b)
      !busy_ff |-> !tx_ff.valid && state_ff == hdr_pkg::ST_IDLE)
      else $error("idle flag with transfer open");

endmodule // hdr_rom

/* File: tb/hdr_host_sink.sv */
////////////////////////////////////////////////////////////////////////
// host side model: takes the descriptor byte stream, prompt or slow
module hdr_host_sink
(
   input wire logic clk,
   input wire logic rst_b,
   input wire hdr_pkg::hdr_tx_type txOut,
   input wire logic slow,
   output logic txReady
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] got[$]; // bytes taken, in arrival order
   logic gotEnd[$]; // packet end flag of each byte taken
   logic lastTaken; // last flag of the newest byte taken
   ////////////////////////////////////////////////////////////////////
   // slow mode stalls every other cycle so bytes must stand until taken
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         txReady <= 1'b0;
         lastTaken <= 1'b0;
      end
      else
      begin
         txReady <= slow ? ~txReady : 1'b1;
         if (txOut.valid && txReady)
         begin
            got.push_back(txOut.data);
            gotEnd.push_back(txOut.pktEnd);
            lastTaken <= txOut.last;
         end
      end
   end
endmodule // hdr_host_sink

/* File: tb/hub_descriptor_rom_tb.sv */
////////////////////////////////////////////////////////////////////////
module hub_descriptor_rom_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst_b;
   logic ce, idLoad, modeLoad, modeStringEnable, overcurrentUsed;
   logic reqValid, txReady, reqStall, busy, stringEnabled, slow;
   logic [15:0] vidIn, pidIn;
   logic [7:0] siliconRelease;
   hdr_pkg::hdr_req_type req;
   hdr_pkg::hdr_tx_type txOut;
   int numErrors = 0;
   int testsRun = 0;
   logic stalled; // a refusal pulse was seen for the last request
   logic sawBusy; // busy was seen high during the last request
   logic [7:0] exp[$]; // expected byte stream
   always #10 clk = ~clk;
   hdr_rom dut (.clk(clk), .rst_b(rst_b), .ce(ce), .idLoad(idLoad),
      .vidIn(vidIn), .pidIn(pidIn), .modeLoad(modeLoad),
      .modeStringEnable(modeStringEnable),
      .siliconRelease(siliconRelease), .overcurrentUsed(overcurrentUsed),
      .reqValid(reqValid), .req(req), .txReady(txReady), .txOut(txOut),
      .reqStall(reqStall), .busy(busy), .stringEnabled(stringEnabled));
   hdr_host_sink host (.clk(clk), .rst_b(rst_b), .txOut(txOut),
      .slow(slow), .txReady(txReady));
   ////////////////////////////////////////////////////////////////////
   task check_val(input string name, input logic [15:0] expV,
      input logic [15:0] gotV);
      testsRun++;
      if (gotV !== expV)
      begin
         numErrors++;
         $display("CHECK FAILED %s expected %h seen %h", name, expV, gotV);
      end
   endtask
   task end_of_test;
      $display("compares %0d mismatches %0d", testsRun, numErrors);
      if (numErrors == 0 && testsRun > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////
   // one request, then wait (bounded) for the transfer to finish
   task run_req(input logic hub, input logic [7:0] typ, input logic [7:0] idx,
      input logic [15:0] len);
      int n;
      host.got.delete();
      host.gotEnd.delete();
      stalled = 1'b0;
      sawBusy = 1'b0;
      @(posedge clk);
      reqValid <= 1'b1;
      req <= '{hub, typ, idx, len};
      @(posedge clk);
      reqValid <= 1'b0;
      for (n = 0; n < 400; n++)
      begin
         @(posedge clk);
         if (reqStall === 1'b1)
            stalled = 1'b1;
         if (busy === 1'b1)
            sawBusy = 1'b1;
         if (n > 3 && busy === 1'b0)
            break;
      end
      if (n == 400)
      begin
         numErrors++;
         $display("CHECK FAILED busy expected 0 seen %b", busy);
         end_of_test;
      end
   endtask
   // whole stream against exp, then the closing flag
   task check_stream(input string name);
      check_val({name, " stall"}, 16'h0000, {15'h0000, stalled});
      check_val({name, " busy"}, 16'h0001, {15'h0000, sawBusy});
      check_val({name, " count"}, 16'(exp.size()), 16'(host.got.size()));
      foreach (exp[i])
         if (i < host.got.size())
         begin
            check_val(name, {8'h00, exp[i]}, {8'h00, host.got[i]});
            // short descriptors fit one packet: the end flag only at the last
            check_val({name, " end"}, {15'h0000, i == exp.size() - 1},
               {15'h0000, host.gotEnd[i]});
         end
      if (exp.size() > 0)
         check_val({name, " last"}, 16'h0001, {15'h0000, host.lastTaken});
   endtask
   ////////////////////////////////////////////////////////////////////
   // device descriptor, full and cut short by the requested length
   task dev_test(input logic strOn);
      exp = '{8'h12, 8'h01, 8'h10, 8'h01, 8'h09, 8'h00, 8'h00, 8'h40,
         vidIn[7:0], vidIn[15:8], pidIn[7:0], pidIn[15:8], 8'h00,
         siliconRelease, strOn ? 8'h01 : 8'h00, strOn ? 8'h02 : 8'h00,
         8'h00, 8'h01};
      run_req(1'b0, 8'h01, 8'h00, 16'h0040);
      check_stream("device");
      exp = exp[0:2];
      run_req(1'b0, 8'h01, 8'h00, 16'h0003);
      check_stream("device cut");
      // zero length: accepted, no bytes, no stall
      exp.delete();
      run_req(1'b0, 8'h01, 8'h00, 16'h0000);
      check_stream("empty");
   endtask
   // configuration set under a stalling host
   task cfg_test;
      slow <= 1'b1;
      exp = '{8'h09, 8'h02, 8'h19, 8'h00, 8'h01, 8'h01, 8'h00, 8'hA0,
         8'h32, 8'h09, 8'h04, 8'h00, 8'h00, 8'h01, 8'h09, 8'h00, 8'h00,
         8'h00, 8'h07, 8'h05, 8'h81, 8'h03, 8'h01, 8'h00, 8'hFF};
      run_req(1'b0, 8'h02, 8'h00, 16'h00FF);
      check_stream("config");
      slow <= 1'b0;
   endtask
   // hub descriptor under both type codes and both protection options
   task hub_test;
      for (int k = 0; k < 4; k++)
      begin
         overcurrentUsed <= k[0];
         exp = '{8'h09, 8'h29, 8'h03, k[0] ? 8'h0D : 8'h15, 8'h00,
            8'h32, 8'h64, 8'h38, 8'hFF};
         if (k[1])
            exp = exp[0:4];
         run_req(1'b1, k[0] ? 8'h29 : 8'h00, 8'h00, k[1] ? 16'h5 : 16'h9);
         check_stream("hub");
      end
   endtask
   // strings refused until the mode command, then served
   task str_test;
      exp.delete();
      run_req(1'b0, 8'h03, 8'h00, 16'h0004);
      check_val("string refused", 16'h0001, {15'h0000, stalled});
      check_val("string count", 16'h0000, 16'(host.got.size()));
      check_val("string busy", 16'h0000, {15'h0000, sawBusy});
      @(posedge clk);
      modeLoad <= 1'b1;
      modeStringEnable <= 1'b1;
      @(posedge clk);
      modeLoad <= 1'b0;
      @(posedge clk);
      check_val("string enable", 16'h0001, {15'h0000, stringEnabled});
      // a mode command while frozen must not touch the setting
      ce <= 1'b0;
      modeLoad <= 1'b1;
      modeStringEnable <= 1'b0;
      @(posedge clk);
      ce <= 1'b1;
      modeLoad <= 1'b0;
      modeStringEnable <= 1'b1;
      @(posedge clk);
      @(posedge clk);
      check_val("string frozen", 16'h0001, {15'h0000, stringEnabled});
      exp = '{8'h04, 8'h03, 8'h09, 8'h04};
      run_req(1'b0, 8'h03, 8'h00, 16'h0004);
      check_stream("string");
   endtask
   // malformed requests are stalled and start nothing
   task refuse_test;
      exp.delete();
      run_req(1'b1, 8'h01, 8'h00, 16'h0009);
      check_val("hub type stall", 16'h0001, {15'h0000, stalled});
      check_val("hub type busy", 16'h0000, {15'h0000, sawBusy});
      run_req(1'b0, 8'h05, 8'h00, 16'h0007);
      check_val("odd type stall", 16'h0001, {15'h0000, stalled});
      check_val("odd type count", 16'h0000, 16'(host.got.size()));
      // only the language table is held here; other indexes stall
      run_req(1'b0, 8'h03, 8'h01, 16'h0004);
      check_val("index stall", 16'h0001, {15'h0000, stalled});
      check_val("index count", 16'h0000, 16'(host.got.size()));
   endtask
   ////////////////////////////////////////////////////////////////////
   initial
   begin
      rst_b = 1'b0;
      ce = 1'b1;
      idLoad = 1'b0;
      modeLoad = 1'b0;
      modeStringEnable = 1'b0;
      overcurrentUsed = 1'b1;
      reqValid = 1'b0;
      req = '0;
      slow = 1'b0;
      vidIn = 16'hA5C3;
      pidIn = 16'h5E7B;
      siliconRelease = 8'h37;
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      idLoad <= 1'b1;
      @(posedge clk);
      idLoad <= 1'b0;
      dev_test(1'b0);
      cfg_test;
      hub_test;
      str_test;
      refuse_test;
      dev_test(1'b1);
      end_of_test;
   end
endmodule // hub_descriptor_rom_tb
